// *** fpsw_top.sv ***
// frame phase status word: backplane phase counter, capture, freeze port
//
// Notes on behaviour
// - phase counter counts backplane clock cycles, restarts each system frame pulse
// - low byte spans 0-255 at 2.048 MHz, 0-192 at 1.544 MHz
// - bits 7:3 give channel number, bits 2:0 give bit in channel
// - line frame pulse captures the current system-frame count
// - captured word refreshes on every line frame pulse unless frozen
// - ninth bit is a frame count toggling across frame boundaries
// - toggle when position passes last channel end or drops below zero
// - compare bits 7:5; toggle only 000 to 11X/1X1 and back
// - a write to either phase address freezes both registers
// - reading the low byte releases the freeze
// - captures fall when line clock is faster, rise when slower
// - rate select picks 2.048 MHz or 1.544 MHz backplane timing
`timescale 1ns/100ps

module fpsw_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    input  wire logic              ce_in,
    input  wire logic              backplane_receive_clock_in,
    input  wire logic              system_frame_pulse_in,
    input  wire logic              line_frame_pulse_in,
    input  wire logic              backplane_2m_select_in,
    input  wire logic              chip_select_n_in,
    input  wire logic              read_strobe_n_in,
    input  wire logic              write_strobe_n_in,
    input  wire logic [ADDR_W-1:0] address_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe_n_out,
    output logic                   frozen_out
);

    initial begin
        if (ADDR_W < 8) begin
            $error("fpsw_top: ADDR_W must hold the register offsets");
        end
    end

    // ------------------------------------------------------------------
    // synchronisers: every timing and bus input pin passes two flip-flops before use; ce_in and rstn_in do not
    // ------------------------------------------------------------------
    localparam int PIN_W = 4;

    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins_sync;
    logic [2:0]       strobe_n_sync;
    logic             strobe_sync_rd;
    logic             strobe_sync_wr;
    logic [ADDR_W-1:0] addr_sync;

    assign pins_async = {backplane_receive_clock_in,
                         system_frame_pulse_in,
                         line_frame_pulse_in,
                         backplane_2m_select_in};

    fpsw_sync #(
        .WIDTH (PIN_W),
        .INIT  (1'b0)
    ) u_pin_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .ce_in    (ce_in),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // each bus pin crosses on its own: gating chip select with a strobe
    // ahead of the flops could let a skew glitch through as an access
    fpsw_sync #(
        .WIDTH (3),
        .INIT  (1'b1)
    ) u_strobe_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .ce_in    (ce_in),
        .async_in ({chip_select_n_in, read_strobe_n_in, write_strobe_n_in}),
        .sync_out (strobe_n_sync)
    );

    assign strobe_sync_rd = ~strobe_n_sync[2] & ~strobe_n_sync[1];
    assign strobe_sync_wr = ~strobe_n_sync[2] & ~strobe_n_sync[0];

    // address is delayed as much as the strobes so both line up
    fpsw_sync #(
        .WIDTH (ADDR_W),
        .INIT  (1'b0)
    ) u_addr_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .ce_in    (ce_in),
        .async_in (address_in),
        .sync_out (addr_sync)
    );

    logic bp_clk_sync;
    logic sys_fp_sync;
    logic line_fp_sync;
    logic sel_2m_sync;

    assign bp_clk_sync  = pins_sync[3];
    assign sys_fp_sync  = pins_sync[2];
    assign line_fp_sync = pins_sync[1];
    assign sel_2m_sync  = pins_sync[0];

    // ------------------------------------------------------------------
    // edge detection on the synchronised levels
    // ------------------------------------------------------------------
    // detectors reset low, the idle level of every pulse and strobe
    logic bp_clk_d_reg;
    logic sys_fp_d_reg;
    logic line_fp_d_reg;
    logic rd_d_reg;
    logic wr_d_reg;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bp_clk_d_reg  <= 1'b0;
            sys_fp_d_reg  <= 1'b0;
            line_fp_d_reg <= 1'b0;
            rd_d_reg      <= 1'b0;
            wr_d_reg      <= 1'b0;
        end else if (ce_in) begin
            bp_clk_d_reg  <= bp_clk_sync;
            sys_fp_d_reg  <= sys_fp_sync;
            line_fp_d_reg <= line_fp_sync;
            rd_d_reg      <= strobe_sync_rd;
            wr_d_reg      <= strobe_sync_wr;
        end
    end

    wire bp_tick   = bp_clk_sync & ~bp_clk_d_reg;
    wire sys_frame = sys_fp_sync & ~sys_fp_d_reg;
    wire line_fp   = line_fp_sync & ~line_fp_d_reg;

    fpsw_pkg::fpsw_access_t acc;

    assign acc.rd_start = strobe_sync_rd & ~rd_d_reg;
    assign acc.rd_end   = ~strobe_sync_rd & rd_d_reg;
    assign acc.wr_start = strobe_sync_wr & ~wr_d_reg;
    assign acc.addr     = addr_sync[7:0];

    // upper address bits, if any, must be zero to hit this block
    wire addr_upper_zero = (ADDR_W == 8) ? 1'b1
                         : (addr_sync >> 8) == '0;

    wire hit_low   = addr_upper_zero
                   & (acc.addr == fpsw_pkg::FPSW_OFS_LOW_BYTE);
    wire hit_frame = addr_upper_zero
                   & (acc.addr == fpsw_pkg::FPSW_OFS_FRAME_BIT);
    wire hit_any   = hit_low | hit_frame;

    // ------------------------------------------------------------------
    // phase counter on the backplane receive clock
    // ------------------------------------------------------------------
    logic [7:0] count_reg;
    logic [7:0] count_next;

    // count limit follows the selected backplane rate
    wire [7:0] last_count = sel_2m_sync ? fpsw_pkg::FPSW_LAST_COUNT_2M
                                        : fpsw_pkg::FPSW_LAST_COUNT_1M5;

    always_comb begin
        count_next = count_reg;
        if (sys_frame) begin
            count_next = fpsw_pkg::FPSW_RESET_COUNT;
        end else if (bp_tick) begin
            if (count_reg >= last_count) begin
                count_next = fpsw_pkg::FPSW_RESET_COUNT;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg <= fpsw_pkg::FPSW_RESET_COUNT;
        end else if (ce_in) begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------------
    // wrap detection on bits 7:5 of previous and current captures
    // ------------------------------------------------------------------
    function automatic logic upper_zone(input logic [2:0] top);
        // 11X or 1X1: the tail end of a frame
        upper_zone = (top[2] & top[1]) | (top[2] & top[0]);
    endfunction

    function automatic logic wraps(input logic [2:0] prev,
                                   input logic [2:0] curr);
        wraps = ((prev == 3'h0) & upper_zone(curr))
              | (upper_zone(prev) & (curr == 3'h0));
    endfunction

    // ------------------------------------------------------------------
    // capture and freeze
    // ------------------------------------------------------------------
    fpsw_pkg::fpsw_phase_t phase_reg;
    fpsw_pkg::fpsw_phase_t phase_next;
    logic                  frozen_reg;
    logic                  frozen_next;

    wire [2:0] prev_top = phase_reg.channel[4:2];
    wire [2:0] curr_top = count_reg[fpsw_pkg::FPSW_WRAP_MSB:
                                    fpsw_pkg::FPSW_WRAP_LSB];
    wire       wrap_hit = wraps(prev_top, curr_top);

    // a write in the same cycle already blocks the capture, so the
    // value software reads is never one that landed after its write
    wire freeze_evt  = acc.wr_start & hit_any;
    wire release_evt = acc.rd_start & hit_low;
    wire capture_ok  = line_fp & ~frozen_reg & ~freeze_evt;

    always_comb begin
        phase_next = phase_reg;
        if (capture_ok) begin
            phase_next.channel = count_reg[fpsw_pkg::FPSW_CHAN_MSB:
                                           fpsw_pkg::FPSW_CHAN_LSB];
            phase_next.bitpos  = count_reg[fpsw_pkg::FPSW_BIT_MSB:
                                           fpsw_pkg::FPSW_BIT_LSB];
            phase_next.frame_bit = phase_reg.frame_bit ^ wrap_hit;
        end
    end

    // a write after the release read re-freezes; freeze wins a tie
    always_comb begin
        frozen_next = frozen_reg;
        if (freeze_evt) begin
            frozen_next = 1'b1;
        end else if (release_evt) begin
            frozen_next = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase_reg  <= fpsw_pkg::FPSW_RESET_PHASE;
            frozen_reg <= fpsw_pkg::FPSW_RESET_FROZEN;
        end else if (ce_in) begin
            phase_reg  <= phase_next;
            frozen_reg <= frozen_next;
        end
    end

    // ------------------------------------------------------------------
    // read path: data and bus enable held from read start to read end
    // ------------------------------------------------------------------
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       oe_n_reg;
    logic       oe_n_next;

    // read value is taken from the word as it stood before this cycle;
    // the release read of the low byte therefore returns frozen data
    wire [7:0] low_byte  = {phase_reg.channel, phase_reg.bitpos};
    wire [7:0] frame_byte = {7'h00, phase_reg.frame_bit};

    wire [7:0] rd_value = hit_low   ? low_byte
                        : hit_frame ? frame_byte
                        : fpsw_pkg::FPSW_RESET_RD_DATA;

    always_comb begin
        rd_data_next = rd_data_reg;
        oe_n_next    = oe_n_reg;
        if (acc.rd_start) begin
            rd_data_next = rd_value;
            oe_n_next    = ~hit_any;
        end else if (acc.rd_end) begin
            oe_n_next    = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_reg <= fpsw_pkg::FPSW_RESET_RD_DATA;
            oe_n_reg    <= 1'b1;
        end else if (ce_in) begin
            rd_data_reg <= rd_data_next;
            oe_n_reg    <= oe_n_next;
        end
    end

    assign data_out      = rd_data_reg;
    assign data_oe_n_out = oe_n_reg;
    assign frozen_out    = frozen_reg;

endmodule

// *** fpsw_pkg.sv ***
// package: constants and types for the frame phase status word block
package fpsw_pkg;

    // register offsets on the microprocessor port
    localparam logic [7:0] FPSW_OFS_LOW_BYTE  = 8'h0E;
    localparam logic [7:0] FPSW_OFS_FRAME_BIT = 8'h0F;

    // field positions inside the phase word
    localparam int FPSW_CHAN_MSB = 7;
    localparam int FPSW_CHAN_LSB = 3;
    localparam int FPSW_BIT_MSB  = 2;
    localparam int FPSW_BIT_LSB  = 0;
    localparam int FPSW_WRAP_MSB = 7;
    localparam int FPSW_WRAP_LSB = 5;

    // last count value of a system frame for each backplane rate
    localparam logic [7:0] FPSW_LAST_COUNT_2M  = 8'hFF;
    localparam logic [7:0] FPSW_LAST_COUNT_1M5 = 8'hC0;

    // values after reset
    localparam logic [7:0] FPSW_RESET_COUNT    = 8'h00;
    localparam logic [7:0] FPSW_RESET_RD_DATA  = 8'h00;
    localparam logic       FPSW_RESET_FROZEN   = 1'b0;

    // synchroniser depth in clock cycles
    localparam int FPSW_SYNC_STAGES = 2;

    // captured phase word: frame bit over channel over bit in channel
    typedef struct packed {
        logic       frame_bit;
        logic [4:0] channel;
        logic [2:0] bitpos;
    } fpsw_phase_t;

    localparam fpsw_phase_t FPSW_RESET_PHASE = '{
        frame_bit : 1'b0,
        channel   : 5'h00,
        bitpos    : 3'h0
    };

    // one decoded access on the microprocessor port
    typedef struct packed {
        logic       rd_start;
        logic       rd_end;
        logic       wr_start;
        logic [7:0] addr;
    } fpsw_access_t;

endpackage

// *** fpsw_sync.sv ***
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/100ps

module fpsw_sync #(
    parameter int        WIDTH = 1,
    parameter logic      INIT  = 1'b0
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("fpsw_sync: WIDTH must be at least 1");
        end
    end

    // first stage is read by the second stage only
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= {WIDTH{INIT}};
            sync_reg <= {WIDTH{INIT}};
        end else if (ce_in) begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// *** fpsw_checker.sv ***
// checker: port-level timing of the phase word bus and freeze
`timescale 1ns/100ps
module fpsw_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clock_in,
    input wire logic              rstn_in,
    input wire logic              chip_select_n_in,
    input wire logic              read_strobe_n_in,
    input wire logic              write_strobe_n_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic [7:0]        data_out,
    input wire logic              data_oe_n_out,
    input wire logic              frozen_out
);
    wire rd = !chip_select_n_in && !read_strobe_n_in;
    wire wr = !chip_select_n_in && !write_strobe_n_in;
    wire lo = address_in == ADDR_W'(fpsw_pkg::FPSW_OFS_LOW_BYTE);
    wire hi = address_in == ADDR_W'(fpsw_pkg::FPSW_OFS_FRAME_BIT);
    default clocking cb @(posedge clock_in);
    endclocking
    // checks wait three edges after reset so that no $past, $rose or
    // $stable looks back at a flop that was still unknown
    logic [1:0] live_reg;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            live_reg <= 2'h0;
        end else if (live_reg != 2'h3) begin
            live_reg <= live_reg + 2'h1;
        end
    end
    default disable iff (!rstn_in || live_reg != 2'h3);
    // strobes shorter than three samples are outside the contract
    sequence rd_go;
        rd && !$past(rd) ##1 rd [*2];
    endsequence
    sequence wr_go;
        wr && !$past(wr) ##1 wr [*2];
    endsequence
    AST_RD_ANSWER: assert property (
        rd_go ##0 (lo || hi) |=> !data_oe_n_out)
        else $error("phase read not answered in time");
    AST_OE_CAUSE: assert property (
        !data_oe_n_out |-> $past(rd && (lo || hi), 3))
        else $error("bus driven without a phase read");
    AST_HI_BYTE: assert property (
        !data_oe_n_out && $past(hi, 3) |-> data_out[7:1] == 7'h00)
        else $error("upper bits of frame bit register not zero");
    AST_UNMAPPED: assert property (
        rd_go ##0 !(lo || hi) |=> data_oe_n_out && data_out == 8'h00)
        else $error("unmapped read answered");
    AST_FREEZE_SET: assert property (
        wr_go ##0 (lo || hi) |=> frozen_out)
        else $error("write did not freeze");
    AST_FREEZE_HOLD: assert property (
        frozen_out && !$past(rd && lo, 2) |=> frozen_out)
        else $error("freeze lost without low byte read");
    AST_FREEZE_RISE: assert property (
        $rose(frozen_out) |-> $past(wr && (lo || hi), 3))
        else $error("freeze without a phase write");
    AST_FREEZE_FALL: assert property (
        $fell(frozen_out) |-> $past(rd && lo, 3))
        else $error("freeze released without low byte read");
    AST_DATA_HOLDS: assert property (
        !$stable(data_out) |-> $past(rd, 3))
        else $error("read data changed without a read");
    C_FREEZE: cover property ($rose(frozen_out));
    C_RELEASE: cover property ($fell(frozen_out));
    C_UNMAPPED: cover property (rd_go ##0 !(lo || hi));
endmodule

// *** fpsw_timing_model.sv ***
// partner: backplane clock and system frame pulse source
`timescale 1ns/100ps
module fpsw_timing_model (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       rate_2m_in,
    output logic            bp_clock_out,
    output logic            frame_pulse_out,
    output logic            mid_out,
    output logic [7:0]      phase_out
);
    logic [2:0] div_reg;
    wire  [7:0] last = rate_2m_in ? 8'hFF : 8'hC0;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_reg <= 3'h0;
            phase_out <= 8'h00;
        end else begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == 3'h3)
                phase_out <= (phase_out == last) ? 8'h00 : phase_out + 8'h01;
        end
    end
    // clock low in reset so no tick is seen at release
    assign bp_clock_out = div_reg[2];
    assign mid_out = div_reg == 3'h0;
    // pulse sits between ticks so restart never races an increment
    assign frame_pulse_out = phase_out == 8'h00 && !div_reg[2];
endmodule

// *** frame_phase_status_word_tb.sv ***
// testbench: capture, frame bit and freeze protocol of the phase word
`timescale 1ns/100ps
module frame_phase_status_word_tb;
    logic       clock_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       sel = 1'b1;
    logic       cs_n = 1'b1;
    logic       rd_n = 1'b1;
    logic       wr_n = 1'b1;
    logic       lfp = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] data_out;
    logic       data_oe_n_out;
    logic       frozen_out;
    logic       bp;
    logic       sfp;
    logic       mid;
    logic [7:0] ph;
    logic [7:0] d;
    logic       oe;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cyc = 0;
    logic [7:0] ks [11] = '{8'h01, 8'hE0, 8'h40, 8'hC8, 8'h05, 8'hA0,
                            8'h03, 8'h80, 8'h02, 8'hC0, 8'h03};
    logic       fb [11] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
                            1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    always #5 clock_in = ~clock_in;
    fpsw_timing_model u_fpsw_timing_model (.clock_in(clock_in),
        .rstn_in(rstn_in), .rate_2m_in(sel), .bp_clock_out(bp),
        .frame_pulse_out(sfp), .mid_out(mid), .phase_out(ph));
    fpsw_top u_fpsw_top (.clock_in(clock_in), .rstn_in(rstn_in),
        .ce_in(1'b1), .backplane_receive_clock_in(bp),
        .system_frame_pulse_in(sfp), .line_frame_pulse_in(lfp),
        .backplane_2m_select_in(sel), .chip_select_n_in(cs_n),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
        .address_in(addr), .data_out(data_out),
        .data_oe_n_out(data_oe_n_out), .frozen_out(frozen_out));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a);
        @(posedge clock_in);
        addr <= a;
        @(posedge clock_in);
        cs_n <= 1'b0;
        if (w)
            wr_n <= 1'b0;
        else
            rd_n <= 1'b0;
        repeat (4) @(posedge clock_in);
        #1 d = data_out;
        oe = data_oe_n_out;
        @(posedge clock_in);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (5) @(posedge clock_in);
    endtask
    // line pulse launched mid-period so it lands k ticks after restart
    task automatic cap(input logic [7:0] k);
        do @(posedge clock_in);
        while (!(ph == k && mid));
        lfp <= 1'b1;
        repeat (3) @(posedge clock_in);
        lfp <= 1'b0;
        repeat (6) @(posedge clock_in);
    endtask
    task automatic word(input logic [7:0] wa, input logic [8:0] e);
        acc(1'b1, wa);
        cmp("frozen", 8'h01, {7'h00, frozen_out});
        acc(1'b0, 8'h0F);
        cmp("frame bit", {7'h00, e[8]}, d);
        cmp("drive", 8'h00, {7'h00, oe});
        acc(1'b0, 8'h0E);
        cmp("low byte", e[7:0], d);
        cmp("released", 8'h00, {7'h00, frozen_out});
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            cap(ks[i]);
            word(i[0] ? 8'h0E : 8'h0F, {fb[i], ks[i]});
        end
        cap(8'h10);
        acc(1'b1, 8'h0E);
        cap(8'h30);
        word(8'h0F, {1'b0, 8'h10});
        cap(8'h30);
        word(8'h0E, {1'b0, 8'h30});
        acc(1'b0, 8'h0D);
        cmp("unmapped data", 8'h00, d);
        cmp("unmapped drive", 8'h01, {7'h00, oe});
        acc(1'b1, 8'h0D);
        cmp("unmapped write", 8'h00, {7'h00, frozen_out});
        rstn_in <= 1'b0;
        sel <= 1'b0;
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 9; i < 11; i++) begin
            cap(ks[i]);
            word(8'h0F, {fb[i], ks[i]});
        end
        tally_and_finish();
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
endmodule
bind fpsw_top fpsw_checker #(.ADDR_W(ADDR_W)) u_fpsw_checker (
    .clock_in(clock_in), .rstn_in(rstn_in),
    .chip_select_n_in(chip_select_n_in),
    .read_strobe_n_in(read_strobe_n_in),
    .write_strobe_n_in(write_strobe_n_in), .address_in(address_in),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .frozen_out(frozen_out));
